/* File: core/tkmc_top.sv */
// Purpose: touch key mode control with APB register access
// Assumes: touch detections and straps synchronous to MCLK
// Notes: straps are sampled once after reset release
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - keys 0-3 form group one, 4-7 group two in two-group modes.
// - straps hi,lo: 11 all single, 10 two single, 01 single+multi, 00 multi.
// - open strap reads 1 by pull-up; resistor to ground reads 0.
// - single-key group grants the lowest index touched key.
// - sleep sampling rate 8 Hz when strap is 1, 64 Hz when 0.
// - sleep sampling window 4 ms when strap is 1, 2 ms when 0.
// - enabled timeout past 80 s returns to calibration, keys off.
// - timeout disabled when strap reads 1, enabled when 0.
// - after reset calibrate with functions off, then go to stand-by.
// - no touch for over 4 s triggers a re-calibration, repeated.
// - status bit 7 is key 0 down to bit 0 key 7, 1 means on.
module tkmc_top
   import tkmc_pkg::*;
#(
   parameter int unsigned CAL_TICKS = CAL_MS,
   parameter int unsigned IDLE_TICKS = IDLE_RECAL_MS,
   parameter int unsigned KEYON_TICKS = KEYON_MAX_MS
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] TOUCH_KEY_INPUTS,
   input wire logic GROUP_MODE_SELECT_HI,
   input wire logic GROUP_MODE_SELECT_LO,
   input wire logic SLEEP_RATE_SELECT,
   input wire logic WAKE_WINDOW_SELECT,
   input wire logic KEYON_TIMEOUT_ENABLE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic [7:0] KEY_STATUS,
   output logic WAKE_SAMPLE,
   output logic IRQ
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   tkmc_state_t state;
   logic [1:0] mode;
   logic rate_fast;
   logic win_short;
   logic tmo_en;
   logic [15:0] tick_cnt;
   logic tick;
   logic [16:0] ms_cnt;
   logic [16:0] idle_cnt;
   logic [16:0] on_cnt;
   logic [6:0] wake_cnt;
   logic [7:0] granted;
   logic [7:0] next_status;
   logic [1:0] ctrl;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_set;
   logic wr;
   logic rd;
   logic timeout;
   logic recal;
   logic active;
   logic [6:0] period_ms;
   logic [6:0] win_ms;

   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && PENABLE && !PWRITE;
   assign PREADY = 1'b1;
   assign active = (state == ST_STANDBY);
   assign timeout = active && tmo_en && (on_cnt >= 17'(KEYON_TICKS));
   assign recal = active && ((idle_cnt >= 17'(IDLE_TICKS)) || ctrl[CTRL_RECAL]);

   // ------------------------------------------------------------
   // millisecond tick
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt <= 16'h0000;
      end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end
   assign tick = (tick_cnt == 16'(TICK_CYC - 1));

   // ------------------------------------------------------------
   // strap latch and sequencing
   // ------------------------------------------------------------
   // open straps pull up to 1; mode pins are read as they stand, rate, window and timeout pins inverted
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         mode <= MODE_ALL_SINGLE;
         rate_fast <= 1'b0;
         win_short <= 1'b0;
         tmo_en <= 1'b0;
      end else if (state == ST_STRAP) begin
         mode <= {GROUP_MODE_SELECT_HI, GROUP_MODE_SELECT_LO};
         rate_fast <= !SLEEP_RATE_SELECT;
         win_short <= !WAKE_WINDOW_SELECT;
         tmo_en <= !KEYON_TIMEOUT_ENABLE;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_STRAP;
         ms_cnt <= 17'h00000;
      end else begin
         case (state)
            ST_STRAP: begin
               state <= ST_CAL;
               ms_cnt <= 17'h00000;
            end
            ST_CAL: begin
               if (tick) begin
                  ms_cnt <= ms_cnt + 17'h00001;
               end
               if (ms_cnt >= 17'(CAL_TICKS)) begin
                  state <= ST_STANDBY;
               end
            end
            ST_STANDBY: begin
               ms_cnt <= 17'h00000;
               if (timeout) begin
                  ms_cnt <= 17'h00000;
                  state <= ST_CAL;
               end else if (recal) begin
                  // a calibration shorter than the recal length runs in full
                  ms_cnt <= (CAL_TICKS > RECAL_MS) ? 17'(CAL_TICKS - RECAL_MS) : 17'h00000;
                  state <= ST_CAL;
               end else if (ctrl[CTRL_SLEEP] && TOUCH_KEY_INPUTS == 8'h00) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (TOUCH_KEY_INPUTS != 8'h00 || !ctrl[CTRL_SLEEP]) begin
                  state <= ST_STANDBY;
               end
            end
            default: state <= ST_STRAP;
         endcase
      end
   end

   // ------------------------------------------------------------
   // idle and key-on timers
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         idle_cnt <= 17'h00000;
      end else if (!active || TOUCH_KEY_INPUTS != 8'h00 || recal) begin
         idle_cnt <= 17'h00000;
      end else if (tick) begin
         idle_cnt <= idle_cnt + 17'h00001;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         on_cnt <= 17'h00000;
      end else if (!active || TOUCH_KEY_INPUTS == 8'h00 || timeout) begin
         on_cnt <= 17'h00000;
      end else if (tick && on_cnt != 17'h1ffff) begin
         on_cnt <= on_cnt + 17'h00001;
      end
   end

   // ------------------------------------------------------------
   // sleep wake-up sampling
   // ------------------------------------------------------------
   assign period_ms = rate_fast ? 7'(PERIOD_FAST_MS) : 7'(PERIOD_SLOW_MS);
   assign win_ms = win_short ? 7'(WIN_SHORT_MS) : 7'(WIN_LONG_MS);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         wake_cnt <= 7'h00;
      end else if (state != ST_SLEEP) begin
         wake_cnt <= 7'h00;
      end else if (tick) begin
         wake_cnt <= (wake_cnt >= period_ms - 7'h01) ? 7'h00 : wake_cnt + 7'h01;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         WAKE_SAMPLE <= 1'b0;
      end else begin
         WAKE_SAMPLE <= (state == ST_SLEEP) && (wake_cnt < win_ms);
      end
   end

   // ------------------------------------------------------------
   // key status
   // ------------------------------------------------------------
   tkmc_grant u_grant (
      .keys(TOUCH_KEY_INPUTS),
      .mode(mode),
      .granted(granted)
   );

   // functions are off outside stand-by, and a timeout leaves keys off
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_status[7 - i] = active && !timeout && granted[i];
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         KEY_STATUS <= 8'h00;
      end else begin
         KEY_STATUS <= next_status;
      end
   end

   // ------------------------------------------------------------
   // registers and interrupts
   // ------------------------------------------------------------
   assign irq_set[IRQ_CHANGE] = active && (next_status != KEY_STATUS);
   assign irq_set[IRQ_CAL_DONE] = (state == ST_CAL) && (ms_cnt >= 17'(CAL_TICKS));
   assign irq_set[IRQ_TIMEOUT] = timeout;
   assign irq_set[IRQ_WAKE] = (state == ST_SLEEP) && (TOUCH_KEY_INPUTS != 8'h00);

   // mask kept apart so a mask write cannot hold off the recal self-clear
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl <= CTRL_RESET;
      end else if (wr && PADDR == ADDR_CTRL) begin
         ctrl <= PWDATA[1:0];
      end else if (recal && ctrl[CTRL_RECAL]) begin
         ctrl[CTRL_RECAL] <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_mask <= '0;
      end else if (wr && PADDR == ADDR_IRQ_MASK) begin
         irq_mask <= PWDATA[IRQ_W-1:0];
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat <= '0;
      end else if (wr && PADDR == ADDR_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~PWDATA[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat <= irq_stat | irq_set;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PSLVERR <= 1'b0;
         case (PADDR)
            ADDR_STATUS: PRDATA <= {24'h000000, next_status};
            ADDR_OPTION: PRDATA <= {21'h000000, 3'(state), 3'h0, tmo_en, win_short,
               rate_fast, mode};
            ADDR_CTRL: PRDATA <= {30'h00000000, ctrl};
            ADDR_IRQ_STAT: PRDATA <= {28'h0000000, irq_stat};
            ADDR_IRQ_MASK: PRDATA <= {28'h0000000, irq_mask};
            ADDR_ID: PRDATA <= ID_VALUE;
            default: begin
               PRDATA <= 32'h0000_0000;
               PSLVERR <= 1'b1;
            end
         endcase
      end else if (rd && PADDR == ADDR_IRQ_STAT) begin
         PRDATA <= PRDATA;
      end
   end
endmodule : tkmc_top
`default_nettype wire

/* File: inc/tkmc_pkg.sv */
// Purpose: constants for the touch key mode control block
// Assumes: 10 MHz system clock
// Notes: register offsets are byte addresses on APB
package tkmc_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
   localparam int unsigned CAL_MS = 500;
   localparam int unsigned IDLE_RECAL_MS = 4000;
   localparam int unsigned KEYON_MAX_MS = 80000;
   localparam int unsigned RECAL_MS = 16;
   localparam int unsigned RATE_SLOW_HZ = 8;
   localparam int unsigned RATE_FAST_HZ = 64;
   localparam int unsigned WIN_LONG_MS = 4;
   localparam int unsigned WIN_SHORT_MS = 2;
   localparam int unsigned PERIOD_SLOW_MS = 1000 / RATE_SLOW_HZ;
   localparam int unsigned PERIOD_FAST_MS = 1000 / RATE_FAST_HZ;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_OPTION = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_ID = 8'h14;
   localparam logic [31:0] ID_VALUE = 32'h0000_5a3c; // value is arbitrary
   // ctrl fields
   localparam int unsigned CTRL_SLEEP = 0;
   localparam int unsigned CTRL_RECAL = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // irq fields
   localparam int unsigned IRQ_CHANGE = 0;
   localparam int unsigned IRQ_CAL_DONE = 1;
   localparam int unsigned IRQ_TIMEOUT = 2;
   localparam int unsigned IRQ_WAKE = 3;
   localparam int unsigned IRQ_W = 4;
   // option register fields
   localparam int unsigned OPT_MODE = 0;
   localparam int unsigned OPT_RATE = 2;
   localparam int unsigned OPT_WIN = 3;
   localparam int unsigned OPT_TMO = 4;
   localparam int unsigned OPT_STATE = 8;
   // ------------------------------------------------------------
   // group modes and states
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_ALL_SINGLE = 2'h3;
   localparam logic [1:0] MODE_TWO_SINGLE = 2'h2;
   localparam logic [1:0] MODE_SINGLE_MULTI = 2'h1;
   localparam logic [1:0] MODE_ALL_MULTI = 2'h0;
   typedef enum logic [2:0] {
      ST_STRAP,
      ST_CAL,
      ST_STANDBY,
      ST_SLEEP
   } tkmc_state_t;
endpackage : tkmc_pkg

/* File: core/tkmc_grant.sv */
// Purpose: per-group key grant, single or multi key
// Assumes: keys already debounced
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module tkmc_grant
   import tkmc_pkg::*;
(
   input wire logic [7:0] keys,
   input wire logic [1:0] mode,
   output logic [7:0] granted
);
   logic [7:0] first_all;
   logic [3:0] first_lo;
   logic [3:0] first_hi;
   // ------------------------------------------------------------
   // lowest index wins, strength plays no part
   // ------------------------------------------------------------
   always_comb begin
      first_all = keys & (~keys + 8'h01);
      first_lo = keys[3:0] & (~keys[3:0] + 4'h1);
      first_hi = keys[7:4] & (~keys[7:4] + 4'h1);
      case (mode)
         MODE_ALL_SINGLE: granted = first_all;
         MODE_TWO_SINGLE: granted = {first_hi, first_lo};
         MODE_SINGLE_MULTI: granted = {keys[7:4], first_lo};
         MODE_ALL_MULTI: granted = keys;
         default: granted = keys;
      endcase
   end
endmodule : tkmc_grant
`default_nettype wire

/* File: tb/tkmc_top_asserts.sv */
// Purpose: port checks for the key mode control
// Assumes: straps steady around reset release
// Notes: tick is TICK_CYC clocks
`timescale 1ns/1ps
`default_nettype none
module tkmc_top_asserts
   import tkmc_pkg::*;
#(
   parameter int unsigned CAL_TICKS = 1,
   parameter int unsigned KEYON_TICKS = 1
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] TOUCH_KEY_INPUTS,
   input wire logic GROUP_MODE_SELECT_HI,
   input wire logic GROUP_MODE_SELECT_LO,
   input wire logic KEYON_TIMEOUT_ENABLE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [7:0] PADDR,
   input wire logic PSLVERR,
   input wire logic [7:0] KEY_STATUS
);
   localparam int unsigned CAL_CYC = CAL_TICKS * TICK_CYC - 2;
   localparam int unsigned ON_MAX = (KEYON_TICKS + 2) * TICK_CYC;
   logic armed;
   logic [1:0] mode;
   logic tmo_en;
   int unsigned age;
   int unsigned on_cnt;
   logic [7:0] rev;
   always_comb begin
      for (int i = 0; i < 8; i++) rev[i] = TOUCH_KEY_INPUTS[7 - i];
   end
   // own copy of the strap latch, taken on the first edge after reset
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         armed <= 1'b0;
         mode <= 2'h0;
         tmo_en <= 1'b0;
         age <= 0;
      end else begin
         armed <= 1'b1;
         if (!armed) begin
            mode <= {GROUP_MODE_SELECT_HI, GROUP_MODE_SELECT_LO};
            tmo_en <= !KEYON_TIMEOUT_ENABLE;
         end
         if (age < CAL_CYC) age <= age + 1;
      end
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) on_cnt <= 0;
      else on_cnt <= (KEY_STATUS != 8'h00) ? on_cnt + 1 : 0;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   sequence s_key_reported;
      (KEY_STATUS != 8'h00) && tmo_en;
   endsequence
   a_cal_keys_off: assert property (age < CAL_CYC |-> KEY_STATUS == 8'h00)
      else $error("status active during calibration");
   a_untouched_off: assert property ($past(TOUCH_KEY_INPUTS) == 8'h00 |-> KEY_STATUS == 8'h00)
      else $error("status on with no touch");
   a_multi_direct: assert property (mode == MODE_ALL_MULTI && KEY_STATUS != 8'h00
      |-> KEY_STATUS == $past(rev)) else $error("multi key status mismatch");
   a_single_first: assert property (mode == MODE_ALL_SINGLE && KEY_STATUS != 8'h00
      |-> $onehot(KEY_STATUS) && (KEY_STATUS & $past(rev)) != 8'h00
      && ($past(rev) & ~((KEY_STATUS << 1) - 8'h01)) == 8'h00) else $error("single key grant");
   a_two_single: assert property (mode == MODE_TWO_SINGLE
      |-> $onehot0(KEY_STATUS[7:4]) && $onehot0(KEY_STATUS[3:0])) else $error("group grant");
   a_mixed_groups: assert property (mode == MODE_SINGLE_MULTI && KEY_STATUS != 8'h00
      |-> $onehot0(KEY_STATUS[7:4]) && KEY_STATUS[3:0] == $past(rev[3:0]))
      else $error("mixed group status");
   a_timeout_bound: assert property (s_key_reported |-> on_cnt <= ON_MAX)
      else $error("key on past timeout");
   a_unmapped_err: assert property (PSEL && PENABLE && PADDR > ADDR_ID |-> PSLVERR)
      else $error("no error on unmapped access");
endmodule : tkmc_top_asserts
`default_nettype wire

/* File: tb/tkmc_pads.sv */
// Purpose: touch pads and option strap resistors
// Assumes: detections already valid per key
// Notes: no touch strength, grant order is the block's job
`timescale 1ns/1ps
`default_nettype none
module tkmc_pads (
   input wire logic [7:0] touch,
   input wire logic [4:0] strap_gnd,
   output logic [7:0] key_out,
   output logic [4:0] strap_pin
);
   assign key_out = touch;
   // open strap pulled up, resistor to ground reads low
   assign strap_pin = ~strap_gnd;
endmodule : tkmc_pads
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: register and key status regression
// Assumes: shortened calibration and timeout counts
// Notes: short idle count, so idle recalibration is reached
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
   $display("wrong value %s expected %h seen %h", nm, e, a); n_errors++; end end
module testbench;
   import tkmc_pkg::*;
   localparam int unsigned CAL_T = 1;
   localparam int unsigned KEYON_T = 1;
   localparam int unsigned IDLE_T = 1;
   logic in_win;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, wake, irq, err;
   logic [7:0] paddr, touch, keys, key_status;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] gnd, pin;
   logic [1:0] mm;
   logic [7:0] pats [5] = '{8'hff, 8'h06, 8'ha0, 8'h3c, 8'h00};
   int n_errors = 0;
   int n_checks = 0;
   int n_cyc = 0;
   tkmc_pads u_pads (.touch(touch), .strap_gnd(gnd), .key_out(keys), .strap_pin(pin));
   tkmc_top #(.CAL_TICKS(CAL_T), .IDLE_TICKS(IDLE_T), .KEYON_TICKS(KEYON_T)) DUT (
      .MCLK(mclk), .RST_N(rst_n), .TOUCH_KEY_INPUTS(keys),
      .GROUP_MODE_SELECT_HI(pin[4]), .GROUP_MODE_SELECT_LO(pin[3]),
      .SLEEP_RATE_SELECT(pin[2]), .WAKE_WINDOW_SELECT(pin[1]), .KEYON_TIMEOUT_ENABLE(pin[0]),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .KEY_STATUS(key_status),
      .WAKE_SAMPLE(wake), .IRQ(irq));
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin n_errors++; finish_test(); end
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   // bounded wait until the status is (non)zero
   task automatic wait_status(input logic nz, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((key_status !== 8'h00) != nz && n < lim);
      if ((key_status !== 8'h00) != nz) begin n_errors++; finish_test(); end
   endtask : wait_status
   task automatic start(input logic [4:0] g);
      gnd <= g; rst_n <= 1'b0; touch <= 8'h01;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      wait_status(1'b1, 3 * CAL_T * TICK_CYC);
      `CHK("key0 after cal", 8'h80, key_status)
   endtask : start
   function automatic logic [7:0] expect_status(input logic [1:0] m, input logic [7:0] t);
      logic [7:0] g;
      g = (m == MODE_ALL_MULTI) ? t : (m == MODE_ALL_SINGLE) ? (t & (~t + 8'h01)) :
         {(m == MODE_SINGLE_MULTI) ? t[7:4] : (t[7:4] & (~t[7:4] + 4'h1)),
         t[3:0] & (~t[3:0] + 4'h1)};
      return {<<{g}};
   endfunction : expect_status
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      touch = 0; gnd = 0; rd = 0; err = 0; mm = 0;
      for (int m = 0; m < 4; m++) begin
         mm = 2'(m);
         start({~mm[1], ~mm[0], mm[0], mm[1], 1'b0});
         gnd <= ~gnd; // late strap change must not matter
         apb(1'b0, ADDR_OPTION, 32'h0);
         `CHK("option", {21'h0, ST_STANDBY, 4'h0, mm, mm}, rd)
         foreach (pats[i]) begin
            touch <= pats[i];
            repeat (2) @(posedge mclk);
            `CHK("status", expect_status(mm, pats[i]), key_status)
         end
         if (m == 0) begin
            apb(1'b0, ADDR_ID, 32'h0);
            `CHK("id", ID_VALUE, rd)
            apb(1'b0, 8'h40, 32'h0);
            `CHK("unmapped err", 1'b1, err)
            `CHK("irq masked", 1'b0, irq)
            apb(1'b1, ADDR_IRQ_MASK, 32'(1) << IRQ_CAL_DONE);
            repeat (2) @(posedge mclk);
            `CHK("irq raised", 1'b1, irq)
            apb(1'b1, ADDR_IRQ_STAT, 32'(1) << IRQ_CAL_DONE);
            repeat (2) @(posedge mclk);
            `CHK("irq cleared", 1'b0, irq)
         end
         if (m == 3) begin
            // short window strap: the first window is cut by tick phase
            apb(1'b1, ADDR_CTRL, 32'(1) << CTRL_SLEEP);
            n_cyc = 0;
            do begin
               @(posedge mclk);
               n_cyc++;
            end while (wake !== 1'b1 && n_cyc < 4);
            n_cyc = 0;
            do begin
               @(posedge mclk);
               n_cyc++;
            end while (wake === 1'b1 && n_cyc < 3 * WIN_SHORT_MS * TICK_CYC);
            in_win = n_cyc > (WIN_SHORT_MS - 1) * TICK_CYC &&
               n_cyc <= WIN_SHORT_MS * TICK_CYC + 1;
            `CHK("wake window", 1'b1, in_win)
            touch <= 8'h04;
            repeat (3) @(posedge mclk);
            `CHK("wake touch", 8'h20, key_status)
            apb(1'b0, ADDR_IRQ_STAT, 32'h0);
            `CHK("wake event", 1'b1, rd[IRQ_WAKE])
         end
      end
      start(5'b11001); // all multi, timeout enabled
      wait_status(1'b0, (KEYON_T + 2) * TICK_CYC);
      `CHK("timeout drop", 8'h00, key_status)
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK("timeout event", 1'b1, rd[IRQ_TIMEOUT])
      touch <= 8'h08;
      wait_status(1'b1, 3 * CAL_T * TICK_CYC);
      `CHK("fresh touch", 8'h10, key_status)
      touch <= 8'h00;
      n_cyc = 0;
      do begin
         apb(1'b0, ADDR_OPTION, 32'h0);
         n_cyc++;
      end while (rd[OPT_STATE +: 3] !== ST_CAL && n_cyc < (IDLE_T + 2) * TICK_CYC / 3);
      `CHK("idle recal", ST_CAL, rd[OPT_STATE +: 3])
      finish_test();
   end
endmodule : testbench
bind tkmc_top tkmc_top_asserts #(.CAL_TICKS(CAL_TICKS), .KEYON_TICKS(KEYON_TICKS)) u_chk (
   .MCLK(MCLK), .RST_N(RST_N), .TOUCH_KEY_INPUTS(TOUCH_KEY_INPUTS),
   .GROUP_MODE_SELECT_HI(GROUP_MODE_SELECT_HI), .GROUP_MODE_SELECT_LO(GROUP_MODE_SELECT_LO),
   .KEYON_TIMEOUT_ENABLE(KEYON_TIMEOUT_ENABLE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PSLVERR(PSLVERR), .KEY_STATUS(KEY_STATUS));
`default_nettype wire
